/* design/cfg_bank_consts.svh */
/*
   Offsets, field positions, reset values and counts of the configuration bank.
   Assumes inclusion by bare name from the design modules.
*/
`ifndef CFG_BANK_CONSTS_SVH
`define CFG_BANK_CONSTS_SVH

// ----------------------------------------------------------------
// Configuration space offsets
// ----------------------------------------------------------------
`define CFG_ID 8'h00
`define CFG_CMDSTAT 8'h04
`define CFG_CLASS 8'h08
`define CFG_BAR 8'h10
`define CFG_SUBSYS 8'h2c
`define CFG_CAPPTR 8'h34
`define CFG_INTR 8'h3c

// ----------------------------------------------------------------
// Command and status fields
// ----------------------------------------------------------------
`define CMD_MEM_EN 1
`define CMD_INTX_DIS 10
`define CMD_RW_MASK 16'h0542
`define STAT_PERR 31
`define STAT_SERR 30
`define STAT_FIXED 14'h0010
`define CAP_PTR 8'h50
`define INT_PIN 8'h01
`define DEF_CLASS 24'h070002

// ----------------------------------------------------------------
// Memory window
// ----------------------------------------------------------------
`define BAR_LSB 11
`define WIN_DEV_BIT 10
`define WIN_CH_BIT 9
`define WIN_DEV_ISR 11'h400
`define WIN_DEV_BAUD 11'h404
`define WIN_DEV_EE 11'h408
`define BEAT_STEP 12'h004

// ----------------------------------------------------------------
// Serial memory
// ----------------------------------------------------------------
`define EE_HALF_CYC 5'h10
`define EE_READ_OP 3'h6
`define EE_DATA_FIRST 5'h0a
`define EE_LAST_BIT 5'h19
`define EE_LAST_WORD 3'h7
`define EE_BLANK 16'hffff

`endif

/* design/cfg_bank_pkg.sv */
/*
   Types of the configuration bank: loader states and the state records.
   Assumes the constants header sits beside it.
*/
package cfg_bank_pkg;

   // ----------------------------------------------------------------
   // Serial memory loader
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {EE_IDLE, EE_SELECT, EE_SHIFT, EE_GAP, EE_DONE} ee_state_t;

   typedef struct packed {
      ee_state_t st;
      logic [4:0] div;
      logic sk;
      logic [4:0] bitcnt;
      logic [2:0] word;
      logic [2:0] lastw;
      logic [15:0] shreg;
      logic cs;
      logic dout;
      logic wvalid;
      logic done;
   } ee_regs_t;

   // ----------------------------------------------------------------
   // Register bank
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [2:0] din_s;
      logic din_f;
      logic [15:0] vendor_id;
      logic [15:0] device_id;
      logic [15:0] subven_id;
      logic [15:0] subsys_id;
      logic [23:0] class_code;
      logic ee_present;
      logic [15:0] cmd;
      logic perr;
      logic serr;
      logic [20:0] bar;
      logic [7:0] int_line;
      logic cfg_ack;
      logic [31:0] cfg_rdata;
      logic burst_hit;
      logic [10:0] burst_off;
      logic s1_valid;
      logic s1_we;
      logic s1_dev;
      logic [10:0] s1_off;
      logic [31:0] s1_wdata;
      logic [1:0] uart_req;
      logic mem_ack;
      logic [31:0] mem_rdata;
      logic [1:0] div4;
      logic [1:0] x4;
      logic [2:0] sw_ee;
      logic ee_cs;
      logic ee_sk;
      logic ee_do;
      logic intx;
   } bank_regs_t;

endpackage

/* design/eeprom_autoload.sv */
/*
   Reads the first eight words of the serial memory after reset.
   Assumes a synchronised serial input and the released reset of the bank.
*/
`include "cfg_bank_consts.svh"

module eeprom_autoload
   import cfg_bank_pkg::*;
(
   input wire logic clk,
   input wire logic rst_core_n,
   input wire logic serial_in,
   output logic sel,
   output logic sclk,
   output logic sout,
   output logic word_valid,
   output logic [2:0] word_idx,
   output logic [15:0] word_data,
   output logic done
);

   ee_regs_t r;
   ee_regs_t n;
   logic tick;
   logic [8:0] cmd;
   logic [8:0] cmd_left;

   // ----------------------------------------------------------------
   // Read sequence: start bit, opcode, address, dummy, sixteen data
   // ----------------------------------------------------------------
   always_comb begin
      n = r;
      n.wvalid = 1'b0;
      tick = (r.div == `EE_HALF_CYC - 5'h01);
      n.div = tick ? 5'h00 : r.div + 5'h01;
      cmd = {`EE_READ_OP, 3'h0, r.word};
      // Shifting past the command leaves zero on the line
      cmd_left = cmd << (r.bitcnt + 5'h01);
      case (r.st)
         EE_IDLE: begin
            if (tick) begin
               n.st = EE_SELECT;
            end
         end
         EE_SELECT: begin
            if (tick) begin
               n.cs = 1'b1;
               n.sk = 1'b0;
               n.dout = cmd[8];
               n.bitcnt = 5'h00;
               n.st = EE_SHIFT;
            end
         end
         EE_SHIFT: begin
            if (tick && !r.sk) begin
               n.sk = 1'b1;
               // Data is valid at the rising edge after the dummy zero
               if (r.bitcnt >= `EE_DATA_FIRST) begin
                  n.shreg = {r.shreg[14:0], serial_in};
               end
            end else if (tick) begin
               n.sk = 1'b0;
               if (r.bitcnt == `EE_LAST_BIT) begin
                  n.cs = 1'b0;
                  n.dout = 1'b0;
                  n.wvalid = 1'b1;
                  n.lastw = r.word;
                  n.word = r.word + 3'h1;
                  n.st = (r.word == `EE_LAST_WORD) ? EE_DONE : EE_GAP;
               end else begin
                  n.bitcnt = r.bitcnt + 5'h01;
                  n.dout = cmd_left[8];
               end
            end
         end
         EE_GAP: begin
            // Select must drop for a while between words
            if (tick) begin
               n.st = EE_SELECT;
            end
         end
         EE_DONE: begin
            n.done = 1'b1;
         end
         default: begin
            n.st = EE_IDLE;
         end
      endcase
   end

   // ----------------------------------------------------------------
   // State register
   // ----------------------------------------------------------------
   always_ff @(posedge clk or negedge rst_core_n) begin
      if (!rst_core_n) begin
         r <= '0;
      end else begin
         r <= n;
      end
   end

   assign sel = r.cs;
   assign sclk = r.sk;
   assign sout = r.dout;
   assign word_valid = r.wvalid;
   assign word_idx = r.lastw;
   assign word_data = r.shreg;
   assign done = r.done;

endmodule

/* design/pcie_config_space_regs.sv */
/*
   Configuration space register bank with a 2K memory window, burst decode and
   serial memory customisation.
   Assumes the link layer turns configuration and memory requests into the
   one-cycle strobes below, all on ref_clk, and that UART read data is valid
   in the same cycle as a UART request.
*/
`include "cfg_bank_consts.svh"

module pcie_config_space_regs
   import cfg_bank_pkg::*;
#(
   parameter logic [15:0] DEF_VENDOR_ID = 16'h1f1f, // Arbitrary value
   parameter logic [15:0] DEF_DEVICE_ID = 16'h2e2e, // Arbitrary value
   parameter logic [7:0] REVISION_ID = 8'h01 // Arbitrary value
)
(
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic cfg_valid,
   input wire logic cfg_we,
   input wire logic [7:0] cfg_addr,
   input wire logic [3:0] cfg_be,
   input wire logic [31:0] cfg_wdata,
   output logic cfg_ack,
   output logic [31:0] cfg_rdata,
   input wire logic mem_valid,
   input wire logic mem_sop,
   input wire logic mem_we,
   input wire logic [31:0] mem_addr,
   input wire logic [31:0] mem_wdata,
   output logic mem_ack,
   output logic [31:0] mem_rdata,
   output logic [1:0] uart_req,
   output logic uart_we,
   output logic [8:0] uart_off,
   output logic [31:0] uart_wdata,
   input wire logic [31:0] uart_rdata,
   input wire logic parity_err,
   input wire logic system_err,
   input wire logic [1:0] uart_irq,
   input wire logic timer_irq,
   input wire logic [15:0] multipurpose_io_irq,
   input wire logic wake_irq,
   output logic intx_assert,
   output logic [1:0] prescale_div4,
   output logic [1:0] sample_4x,
   output logic eeprom_chip_select,
   output logic eeprom_serial_clock,
   output logic eeprom_serial_out,
   input wire logic eeprom_serial_in
);

   bank_regs_t r;
   bank_regs_t n;
   logic [1:0] rst_sync_r;
   logic rst_core_n;
   logic ld_cs;
   logic ld_sk;
   logic ld_do;
   logic ld_valid;
   logic [2:0] ld_idx;
   logic [15:0] ld_data;
   logic ld_done;
   logic cfg_wr;
   logic [31:0] wmask;
   logic [15:0] cmd_mask;
   logic hit;
   logic [10:0] off;
   logic [11:0] sum;
   logic [31:0] dev_rd;

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_core_n);

   // ----------------------------------------------------------------
   // Reset release
   // ----------------------------------------------------------------
   // Assert at once, release two edges later so no flop sees a runt
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         rst_sync_r <= 2'h0;
      end else begin
         rst_sync_r <= {rst_sync_r[0], 1'b1};
      end
   end
   assign rst_core_n = rst_sync_r[1];

   // ----------------------------------------------------------------
   // Serial memory loader
   // ----------------------------------------------------------------
   eeprom_autoload u_loader (
      .clk(ref_clk),
      .rst_core_n(rst_core_n),
      .serial_in(r.din_f),
      .sel(ld_cs),
      .sclk(ld_sk),
      .sout(ld_do),
      .word_valid(ld_valid),
      .word_idx(ld_idx),
      .word_data(ld_data),
      .done(ld_done)
   );

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   always_comb begin
      n = r;
      cfg_wr = cfg_valid && cfg_we;
      wmask = {{8{cfg_be[3]}}, {8{cfg_be[2]}}, {8{cfg_be[1]}}, {8{cfg_be[0]}}};
      cmd_mask = wmask[15:0] & `CMD_RW_MASK;

      // Pin input: three stages, a change counts when two agree
      n.din_s = {r.din_s[1:0], eeprom_serial_in};
      if (r.din_s[1] == r.din_s[2]) begin
         n.din_f = r.din_s[2];
      end

      // Autoload: a blank first word means no memory is fitted
      if (ld_valid) begin
         case (ld_idx)
            3'h0: begin
               n.ee_present = (ld_data != `EE_BLANK);
               if (ld_data != `EE_BLANK) begin
                  n.vendor_id = ld_data;
               end
            end
            3'h1: n.device_id = r.ee_present ? ld_data : r.device_id;
            3'h2: n.subven_id = r.ee_present ? ld_data : r.subven_id;
            3'h3: n.subsys_id = r.ee_present ? ld_data : r.subsys_id;
            3'h4: n.class_code[23:8] = r.ee_present ? ld_data : r.class_code[23:8];
            3'h5: n.class_code[7:0] = r.ee_present ? ld_data[7:0] : r.class_code[7:0];
            default: begin
            end
         endcase
      end

      // Error flags: a new event wins over a write-one clear
      n.perr = parity_err || (r.perr && !(cfg_wr && cfg_addr == `CFG_CMDSTAT &&
               cfg_be[3] && cfg_wdata[`STAT_PERR]));
      n.serr = system_err || (r.serr && !(cfg_wr && cfg_addr == `CFG_CMDSTAT &&
               cfg_be[3] && cfg_wdata[`STAT_SERR]));

      // Configuration writes touch only the writable bits
      if (cfg_wr) begin
         case (cfg_addr)
            `CFG_CMDSTAT: n.cmd = (r.cmd & ~cmd_mask) | (cfg_wdata[15:0] & cmd_mask);
            `CFG_BAR: n.bar = (r.bar & ~wmask[31:`BAR_LSB]) | (cfg_wdata[31:`BAR_LSB] & wmask[31:`BAR_LSB]);
            `CFG_INTR: n.int_line = cfg_be[0] ? cfg_wdata[7:0] : r.int_line;
            default: begin
            end
         endcase
      end

      // Configuration reads answer one cycle after the strobe
      n.cfg_ack = cfg_valid;
      // Read data moves only on a request, so it stands until the next answer
      if (cfg_valid) begin
         case (cfg_addr)
            `CFG_ID: n.cfg_rdata = {r.device_id, r.vendor_id};
            `CFG_CMDSTAT: n.cfg_rdata = {r.perr, r.serr, `STAT_FIXED, r.cmd};
            `CFG_CLASS: n.cfg_rdata = {r.class_code, REVISION_ID};
            `CFG_BAR: n.cfg_rdata = {r.bar, 11'h000};
            `CFG_SUBSYS: n.cfg_rdata = {r.subsys_id, r.subven_id};
            `CFG_CAPPTR: n.cfg_rdata = {24'h000000, `CAP_PTR};
            `CFG_INTR: n.cfg_rdata = {16'h0000, `INT_PIN, r.int_line};
            default: n.cfg_rdata = 32'h00000000;
         endcase
      end

      // Memory decode: first beat matches the base, later beats follow on
      hit = 1'b0;
      off = r.burst_off;
      if (mem_valid && mem_sop) begin
         hit = r.cmd[`CMD_MEM_EN] && (mem_addr[31:`BAR_LSB] == r.bar);
         off = mem_addr[10:0];
      end else if (mem_valid) begin
         hit = r.burst_hit && r.cmd[`CMD_MEM_EN];
      end
      sum = {1'b0, off} + `BEAT_STEP;
      if (mem_valid) begin
         n.burst_off = sum[10:0];
         // A burst never wraps past the end of the window
         n.burst_hit = hit && !sum[11];
      end
      n.s1_valid = hit;
      n.s1_we = mem_we;
      n.s1_off = off;
      n.s1_wdata = mem_wdata;
      n.s1_dev = off[`WIN_DEV_BIT];
      n.uart_req = 2'h0;
      if (hit && !off[`WIN_DEV_BIT]) begin
         n.uart_req = off[`WIN_CH_BIT] ? 2'h2 : 2'h1;
      end

      // Device register writes in the second stage
      if (r.s1_valid && r.s1_we && r.s1_dev) begin
         case (r.s1_off)
            `WIN_DEV_BAUD: begin
               n.div4 = r.s1_wdata[1:0];
               n.x4 = r.s1_wdata[3:2];
            end
            // Autoload owns the pins until it is done
            `WIN_DEV_EE: n.sw_ee = ld_done ? r.s1_wdata[2:0] : r.sw_ee;
            default: begin
            end
         endcase
      end

      // Device register reads; interrupt sources are live levels
      case (r.s1_off)
         `WIN_DEV_ISR: dev_rd = {multipurpose_io_irq, 7'h00, wake_irq, 5'h00, timer_irq, uart_irq};
         `WIN_DEV_BAUD: dev_rd = {28'h0000000, r.x4, r.div4};
         `WIN_DEV_EE: dev_rd = {26'h0000000, r.ee_present, ld_done, r.din_f, r.sw_ee};
         default: dev_rd = 32'h00000000;
      endcase
      n.mem_ack = r.s1_valid;
      n.mem_rdata = r.s1_we ? 32'h00000000 : (r.s1_dev ? dev_rd : uart_rdata);

      // Serial memory pins, handed to software once autoload ends
      n.ee_cs = ld_done ? r.sw_ee[0] : ld_cs;
      n.ee_sk = ld_done ? r.sw_ee[1] : ld_sk;
      n.ee_do = ld_done ? r.sw_ee[2] : ld_do;

      // Legacy interrupt, gated by the disable bit
      n.intx = ((|uart_irq) || timer_irq || (|multipurpose_io_irq) || wake_irq) && !r.cmd[`CMD_INTX_DIS];
   end

   // ----------------------------------------------------------------
   // State register
   // ----------------------------------------------------------------
   always_ff @(posedge ref_clk or negedge rst_core_n) begin
      if (!rst_core_n) begin
         r <= '0;
         r.vendor_id <= DEF_VENDOR_ID;
         r.device_id <= DEF_DEVICE_ID;
         r.class_code <= `DEF_CLASS;
      end else begin
         r <= n;
      end
   end

   // ----------------------------------------------------------------
   // Outputs, all from the state register
   // ----------------------------------------------------------------
   assign cfg_ack = r.cfg_ack;
   assign cfg_rdata = r.cfg_rdata;
   assign mem_ack = r.mem_ack;
   assign mem_rdata = r.mem_rdata;
   assign uart_req = r.uart_req;
   assign uart_we = r.s1_we;
   assign uart_off = r.s1_off[8:0];
   assign uart_wdata = r.s1_wdata;
   assign intx_assert = r.intx;
   assign prescale_div4 = r.div4;
   assign sample_4x = r.x4;
   assign eeprom_chip_select = r.ee_cs;
   assign eeprom_serial_clock = r.ee_sk;
   assign eeprom_serial_out = r.ee_do;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   AST_PERR_SET: assert property (parity_err |=> r.perr)
      else $error("parity flag not set");
   AST_PERR_READ: assert property (cfg_valid && cfg_addr == `CFG_CMDSTAT && r.perr
      |=> cfg_rdata[`STAT_PERR])
      else $error("parity flag not reported");
   AST_PERR_HOLD: assert property (r.perr && !(cfg_valid && cfg_we) |=> r.perr)
      else $error("parity flag dropped without clear");
   AST_SERR_CLR: assert property (r.serr && !system_err && cfg_valid && cfg_we && cfg_addr == `CFG_CMDSTAT
      && cfg_be[3] && cfg_wdata[30] |=> !r.serr)
      else $error("system error flag not cleared");
   AST_ID_READ: assert property (cfg_valid && !cfg_we && cfg_addr == `CFG_ID
      |=> cfg_ack && cfg_rdata == {$past(r.device_id), $past(r.vendor_id)})
      else $error("identity word wrong");
   AST_STAT_FIXED: assert property (cfg_valid && cfg_addr == `CFG_CMDSTAT
      |=> cfg_rdata[29:16] == 14'h0010 && (cfg_rdata[15:0] & 16'hfabd) == 16'h0000)
      else $error("fixed status bits wrong");
   AST_MEM_OFF: assert property (mem_valid && mem_sop && !r.cmd[1] |-> ##2 !mem_ack)
      else $error("memory answered while disabled");
   AST_BAR_HIT: assert property (mem_valid && mem_sop && r.cmd[1] && mem_addr[31:11] == r.bar
      |-> ##2 mem_ack)
      else $error("claimed access not answered");
   AST_BURST: assert property (mem_valid && mem_sop && r.cmd[1] && mem_addr[31:11] == r.bar
      && mem_addr[10:0] < 11'h7fc ##1 mem_valid && !mem_sop && r.cmd[1] |-> ##2 mem_ack)
      else $error("burst beat dropped");
   AST_BURST_END: assert property (mem_valid && mem_sop && r.cmd[1] && mem_addr[10:0] == 11'h7fc
      ##1 mem_valid && !mem_sop |-> ##2 !mem_ack)
      else $error("burst ran past the window");
   AST_INTX_MASK: assert property (r.cmd[10] |=> !intx_assert)
      else $error("interrupt asserted while disabled");
   AST_NO_EE: assert property (ld_done && !r.ee_present |-> r.vendor_id == DEF_VENDOR_ID)
      else $error("defaults lost without memory");

   COV_BURST: cover property (mem_ack ##1 mem_ack ##1 mem_ack);
   COV_ID: cover property (cfg_valid && !cfg_we && cfg_addr == `CFG_ID);
   COV_LOADED: cover property (ld_done && r.ee_present);
   COV_PERR_CLR: cover property (r.perr ##1 !r.perr);

endmodule

/* tb/eeprom_model.sv */
/*
   Serial memory model: answers read frames with one word per address.
   Assumes select, clock and data out come from the bank's pins; with fitted
   low the line stays at its pull-up level, as with no memory on the board.
*/
module eeprom_model (
   input wire logic sel,
   input wire logic sclk,
   input wire logic din,
   input wire logic fitted,
   output logic dout
);
   timeunit 1ns;
   timeprecision 1ps;
   int cnt;
   logic [5:0] addr;
   logic [15:0] word;

   // ----------------------------------------------------------------
   // Frame decode
   // ----------------------------------------------------------------
   // Address bits follow the start bit and the two opcode bits
   always @(posedge sclk or negedge sel) begin
      if (!sel) begin
         cnt <= 0;
      end else begin
         if (cnt >= 3 && cnt <= 8) begin
            addr <= {addr[4:0], din};
         end
         cnt <= cnt + 1;
      end
   end

   // Data moves on the falling clock so it is settled at the next rise
   initial dout = 1'b1;
   always @(negedge sclk or negedge sel) begin
      if (!sel || !fitted) begin
         dout <= 1'b1; // Pull-up level while deselected
      end else if (cnt >= 10 && cnt <= 25) begin
         word = 16'h5a00 | 16'(addr);
         dout <= word[25 - cnt];
      end else begin
         dout <= (cnt != 9); // Dummy zero ahead of the data
      end
   end
endmodule

/* tb/tb.sv */
/*
   Self-checking bench of the configuration bank with a serial memory model.
   Assumes the design package, constants header and bank are compiled first.
*/
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin n_mismatch++; \
   $display("BAD t=%0t got=%h exp=%h", $time, a, e); end end

module tb;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [31:0] BAR_C = 32'h12345800;
   logic ref_clk = 1'b0;
   logic rst_n = 1'b0;
   logic cfg_valid, cfg_we, mem_valid, mem_sop, mem_we, parity_err, system_err, timer_irq, wake_irq;
   logic [7:0] cfg_addr;
   logic [3:0] cfg_be;
   logic [31:0] cfg_wdata, mem_addr, mem_wdata, q;
   logic [1:0] uart_irq;
   logic [15:0] multipurpose_io_irq;
   logic cfg_ack, mem_ack, uart_we, intx_assert, eeprom_serial_in;
   logic eeprom_chip_select, eeprom_serial_clock, eeprom_serial_out;
   logic [31:0] cfg_rdata, mem_rdata, uart_wdata;
   logic [1:0] uart_req, prescale_div4, sample_4x;
   logic [8:0] uart_off;
   wire logic [31:0] uart_rdata = {23'h0, uart_off};
   int n_mismatch = 0;
   int cmp_count = 0;
   int cyc = 0;
   logic ee_fitted = 1'b1;

   pcie_config_space_regs dut (.ref_clk, .rst_n, .cfg_valid, .cfg_we, .cfg_addr, .cfg_be, .cfg_wdata,
      .cfg_ack, .cfg_rdata, .mem_valid, .mem_sop, .mem_we, .mem_addr, .mem_wdata, .mem_ack, .mem_rdata,
      .uart_req, .uart_we, .uart_off, .uart_wdata, .uart_rdata, .parity_err, .system_err, .uart_irq,
      .timer_irq, .multipurpose_io_irq, .wake_irq, .intx_assert, .prescale_div4, .sample_4x, .eeprom_chip_select,
      .eeprom_serial_clock, .eeprom_serial_out, .eeprom_serial_in);
   eeprom_model mdl (.sel(eeprom_chip_select), .sclk(eeprom_serial_clock), .din(eeprom_serial_out),
      .fitted(ee_fitted), .dout(eeprom_serial_in));

   // ----------------------------------------------------------------
   // Clock, hang guard and closing report
   // ----------------------------------------------------------------
   initial forever #20 ref_clk = ~ref_clk;
   // Each autoload needs about 7000 cycles and the run has two, so 60000 leaves wide margin
   always @(posedge ref_clk) begin
      cyc++;
      if (cyc == 60000) begin
         n_mismatch++;
         wrap_up();
      end
   end
   task automatic wrap_up();
      $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
      if (n_mismatch == 0 && cmp_count > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   // ----------------------------------------------------------------
   // Bus tasks
   // ----------------------------------------------------------------
   task automatic tick(input int n = 1);
      repeat (n) @(posedge ref_clk);
      #1;
   endtask
   task automatic cfg(input logic we, input logic [7:0] a, input logic [31:0] d, input logic [3:0] be);
      {cfg_we, cfg_addr, cfg_wdata, cfg_be, cfg_valid} = {we, a, d, be, 1'b1};
      tick();
      cfg_valid = 1'b0;
      `CHK(cfg_ack, 1'b1)
      q = cfg_rdata;
      // One idle edge, so a next call never raises valid in the step that lowered it
      tick();
   endtask
   task automatic mem(input logic we, input logic [31:0] a, input logic [31:0] d);
      {mem_we, mem_addr, mem_wdata, mem_sop, mem_valid} = {we, a, d, 2'b11};
      tick();
      {mem_sop, mem_valid} = 2'b00;
      tick();
      `CHK(mem_ack, 1'b1)
      q = mem_rdata;
   endtask

   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   task automatic t_cmd();
      cfg(1'b0, 8'h00, 32'h0, 4'hf);
      `CHK(q, 32'h2e2e1f1f)
      cfg(1'b1, 8'h04, 32'hffffffff, 4'h1);
      cfg(1'b0, 8'h04, 32'h0, 4'hf);
      `CHK(q, 32'h00100042)
      cfg(1'b1, 8'h04, 32'hffffffff, 4'hf);
      cfg(1'b0, 8'h04, 32'h0, 4'hf);
      `CHK(q, 32'h00100542)
      cfg(1'b1, 8'h04, 32'h00000002, 4'hf);
   endtask
   // Set one error flag at a time, then clear each with a write of one
   task automatic t_err();
      parity_err = 1'b1;
      tick();
      parity_err = 1'b0;
      cfg(1'b0, 8'h04, 32'h0, 4'hf);
      `CHK(q, 32'h80100002)
      system_err = 1'b1;
      tick();
      system_err = 1'b0;
      cfg(1'b1, 8'h04, 32'h80000002, 4'hf);
      cfg(1'b0, 8'h04, 32'h0, 4'hf);
      `CHK(q, 32'h40100002)
      cfg(1'b1, 8'h04, 32'h40000002, 4'hf);
      cfg(1'b0, 8'h04, 32'h0, 4'hf);
      `CHK(q, 32'h00100002)
   endtask
   task automatic t_bar();
      cfg(1'b1, 8'h10, 32'hffffffff, 4'hf);
      cfg(1'b0, 8'h10, 32'h0, 4'hf);
      `CHK(q, 32'hfffff800)
      cfg(1'b1, 8'h10, BAR_C, 4'hf);
   endtask
   // Two back-to-back beats, a beat past the window, a burst off its end, a write
   task automatic t_burst();
      {mem_we, mem_addr, mem_sop, mem_valid} = {1'b0, BAR_C | 32'h4, 2'b11};
      tick();
      mem_sop = 1'b0;
      `CHK({uart_req, uart_we, uart_off}, {2'b01, 1'b0, 9'h004})
      tick();
      mem_valid = 1'b0;
      `CHK({mem_ack, mem_rdata, uart_off}, {1'b1, 32'h4, 9'h008})
      tick();
      `CHK({mem_ack, mem_rdata}, {1'b1, 32'h8})
      {mem_addr, mem_sop, mem_valid} = {BAR_C + 32'h800, 2'b11};
      tick();
      {mem_sop, mem_valid} = 2'b00;
      `CHK(uart_req, 2'b00)
      tick();
      `CHK(mem_ack, 1'b0)
      {mem_addr, mem_sop, mem_valid} = {BAR_C | 32'h7fc, 2'b11};
      tick();
      mem_sop = 1'b0;
      tick();
      mem_valid = 1'b0;
      `CHK(mem_ack, 1'b1)
      tick();
      `CHK(mem_ack, 1'b0)
      {mem_we, mem_addr, mem_wdata, mem_sop, mem_valid} = {1'b1, BAR_C | 32'h204, 32'h0000c0de, 2'b11};
      tick();
      {mem_sop, mem_valid} = 2'b00;
      `CHK({uart_req, uart_we, uart_off, uart_wdata}, {2'b10, 1'b1, 9'h004, 32'h0000c0de})
      tick();
      `CHK({mem_ack, mem_rdata}, {1'b1, 32'h00000000})
   endtask
   task automatic t_dev();
      {uart_irq, timer_irq, multipurpose_io_irq, wake_irq} = {2'b10, 1'b1, 16'h8001, 1'b1};
      mem(1'b0, BAR_C | 32'h400, 32'h0);
      `CHK(q, 32'h80010106)
      mem(1'b1, BAR_C | 32'h404, 32'h6);
      tick(2);
      `CHK({prescale_div4, sample_4x, intx_assert}, {2'b10, 2'b01, 1'b1})
      cfg(1'b1, 8'h04, 32'h00000402, 4'hf);
      tick(2);
      `CHK(intx_assert, 1'b0)
   endtask
   // Poll the device register until the autoload reports done
   task automatic wait_load();
      for (int i = 0; i < 400; i++) begin
         tick(50);
         mem(1'b0, BAR_C | 32'h408, 32'h0);
         if (q[4] === 1'b1) begin
            break;
         end
      end
   endtask
   // Wait for the autoload, then check the loaded identity and pin access
   task automatic t_load();
      wait_load();
      `CHK(q[5:4], 2'b11)
      cfg(1'b0, 8'h00, 32'h0, 4'hf);
      `CHK(q, 32'h5a015a00)
      cfg(1'b0, 8'h2c, 32'h0, 4'hf);
      `CHK(q, 32'h5a035a02)
      cfg(1'b0, 8'h08, 32'h0, 4'hf);
      `CHK(q, 32'h5a040501)
      mem(1'b1, BAR_C | 32'h408, 32'h7);
      tick(2);
      `CHK({eeprom_chip_select, eeprom_serial_clock, eeprom_serial_out}, 3'b111)
      mem(1'b1, BAR_C | 32'h408, 32'h0);
   endtask
   // Reset again with no memory fitted; the defaults must survive the autoload
   task automatic t_blank();
      ee_fitted = 1'b0;
      rst_n = 1'b0;
      tick(4);
      rst_n = 1'b1;
      tick(4);
      cfg(1'b1, 8'h04, 32'h00000002, 4'hf);
      cfg(1'b1, 8'h10, BAR_C, 4'hf);
      wait_load();
      `CHK(q[5:4], 2'b01)
      cfg(1'b0, 8'h00, 32'h0, 4'hf);
      `CHK(q, 32'h2e2e1f1f)
   endtask

   // Main sequence
   initial begin
      {cfg_valid, cfg_we, cfg_addr, cfg_be, cfg_wdata, mem_valid, mem_sop, mem_we, mem_addr} = '0;
      {mem_wdata, parity_err, system_err, uart_irq, timer_irq, multipurpose_io_irq, wake_irq} = '0;
      tick(16);
      rst_n = 1'b1;
      tick(4);
      t_cmd();
      t_err();
      t_bar();
      t_burst();
      t_dev();
      t_load();
      t_blank();
      wrap_up();
   end
endmodule
